/* design/dtp_map.svh */
/*
  Register map and constants of the down timer with two PWM channels.
  Assumes inclusion by its bare name from design files.
*/
`ifndef DTP_MAP_SVH
`define DTP_MAP_SVH
`define DTP_ADDR_COUNTER 8'h10
`define DTP_ADDR_CTRL_ONE 8'h11
`define DTP_ADDR_CTRL_TWO 8'h12
`define DTP_ADDR_DUTY_ONE 8'h13
`define DTP_ADDR_PRESCALE 8'h14
`define DTP_ADDR_CTRL_CH2 8'h16
`define DTP_ADDR_DUTY_TWO 8'h18
`define DTP_ADDR_HIGH_BITS 8'h15
`define DTP_ADDR_IRQ_STATUS 8'h19
`define DTP_ADDR_IRQ_MASK 8'h1A
`define DTP_BIT_RUN 0
`define DTP_BIT_RELOAD 1
`define DTP_BIT_ONESHOT 2
`define DTP_BIT_POL 6
`define DTP_BIT_PIN_EN 7
`define DTP_BIT_BYPASS_N 3
`define DTP_BIT_EDGE 4
`define DTP_BIT_SOURCE 5
`define DTP_CTRL_TWO_RESET 6'h3F
`define DTP_PRESCALE_RESET 8'hFF
`define DTP_COUNT_TOP 10'h3FF
`define DTP_COUNT_ZERO 10'h000
`define DTP_INSTR_DIV 2'h3
`define DTP_UNDERFLOW_BIT 0
`define DTP_PIN_FILL 3'h4
`endif

/* design/dtp_pkg.sv */
/*
  Types shared by the down timer with two PWM channels.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dtp_pkg;
  typedef enum logic [1:0] {
    DTP_SRC_NONE = 2'b00,
    DTP_SRC_INSTR = 2'b01,
    DTP_SRC_EXT = 2'b10
  } dtp_src_t;
endpackage

/* design/dtp_timer.sv */
/*
  Ten-bit down timer with prescaler, clock source select and two PWM channels,
  plus an underflow interrupt. Assumes a plain register port with read data
  one cycle after the read strobe, and one 20 MHz system clock.
*/
// The address-and-strobe port was decided locally.
`include "dtp_map.svh"
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R1] ten-bit down counter, low byte readable
// [R2] counter write loads full reload value
// [R3] run bit starts and halts counting
// [R4] non-stop, reload clear: wrap to 0x3FF
// [R5] non-stop, reload set: load reload value
// [R6] one-shot stops counting at underflow
// [R7] prescaler divides by two to 256
// [R8] bypass bit skips prescaler; change code bypassed
// [R9] edge select picks falling or rising edge
// [R10] source select picks pin or instruction clock
// [R11] first channel polarity bit inverts output
// [R12] first channel pin enable gates pin
// [R13] first channel duty from high bits 1:0
// [R14] second channel polarity bit inverts output
// [R15] second channel pin enable gates pin
// [R16] prescaler live count readable, resets ones
// [R17] second channel duty from high bits 3:2
// [R18] output active while count below duty
// [R19] underflow sets sticky interrupt flag
module dtp_timer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic external_count_pin,
  output logic first_channel_out,
  output logic first_channel_out_en,
  output logic second_channel_out,
  output logic second_channel_out_en,
  output logic irq
);
  logic [7:0] reload_low;
  logic [5:0] shared_high_bits;
  logic [7:0] ctrl_one;
  logic [5:0] ctrl_two;
  logic [7:0] first_channel_duty;
  logic [7:0] second_channel_duty;
  logic [1:0] ctrl_ch2;
  logic [9:0] count;
  logic stopped;
  logic [7:0] prescaler_live_count;
  logic [1:0] instr_div;
  logic [2:0] pin_sync;
  logic count_tick;
  logic src_tick;
  logic pin_rise;
  logic pin_fall;
  logic [2:0] pin_fill;
  logic pin_level;
  logic pin_seen;
  logic counter_write;
  logic clear_write;
  logic underflow;
  logic [0:0] irq_status;
  logic [0:0] irq_mask;
  logic [7:0] next_rdata;
  logic pwm_one;
  logic pwm_two;
  dtp_pkg::dtp_src_t src;

  function automatic logic [9:0] join10(input logic [1:0] hi, input logic [7:0] lo);
    join10 = {hi, lo};
  endfunction

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] b);
    wr_hit = wr && (a == b);
  endfunction

  // control registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reload_low <= 8'h00;
      shared_high_bits <= 6'h00;
      ctrl_one <= 8'h00;
      ctrl_two <= `DTP_CTRL_TWO_RESET;
      first_channel_duty <= 8'h00;
      second_channel_duty <= 8'h00;
      ctrl_ch2 <= 2'h0;
      irq_mask <= 1'b0;
    end else begin
      if (wr_hit(reg_wr, reg_addr, `DTP_ADDR_COUNTER)) reload_low <= reg_wdata;
      if (wr_hit(reg_wr, reg_addr, `DTP_ADDR_HIGH_BITS)) shared_high_bits <= reg_wdata[5:0];
      if (wr_hit(reg_wr, reg_addr, `DTP_ADDR_CTRL_ONE)) ctrl_one <= reg_wdata;
      if (wr_hit(reg_wr, reg_addr, `DTP_ADDR_CTRL_TWO)) ctrl_two <= reg_wdata[5:0];
      if (wr_hit(reg_wr, reg_addr, `DTP_ADDR_DUTY_ONE)) first_channel_duty <= reg_wdata;
      if (wr_hit(reg_wr, reg_addr, `DTP_ADDR_DUTY_TWO)) second_channel_duty <= reg_wdata;
      if (wr_hit(reg_wr, reg_addr, `DTP_ADDR_CTRL_CH2)) ctrl_ch2 <= reg_wdata[7:6];
      if (wr_hit(reg_wr, reg_addr, `DTP_ADDR_IRQ_MASK)) irq_mask <= reg_wdata[0:0];
    end
  end

  // pin synchroniser, three stages
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], external_count_pin};
    end
  end

  // no edge until the stages have filled, so reset gives no false edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_fill <= 3'h0;
    end else if (pin_fill != `DTP_PIN_FILL) begin
      pin_fill <= pin_fill + 3'h1;
    end
  end

  // settled pin level: changes once stages two and three agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_level <= 1'b0;
    end else if (pin_sync[1] == pin_sync[2]) begin
      pin_level <= pin_sync[2];
    end
  end
  assign pin_seen = (pin_fill == `DTP_PIN_FILL);
  assign pin_rise = pin_seen && pin_sync[1] && pin_sync[2] && !pin_level;
  assign pin_fall = pin_seen && !pin_sync[1] && !pin_sync[2] && pin_level;

  // instruction clock: one enable every four system clocks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  always_comb begin
    src = ctrl_two[`DTP_BIT_SOURCE] ? dtp_pkg::DTP_SRC_EXT : dtp_pkg::DTP_SRC_INSTR; // [R10]
    unique case (src)
      dtp_pkg::DTP_SRC_EXT: src_tick = ctrl_two[`DTP_BIT_EDGE] ? pin_fall : pin_rise; // [R9]
      dtp_pkg::DTP_SRC_INSTR: src_tick = (instr_div == `DTP_INSTR_DIV);
      default: src_tick = 1'b0;
    endcase
  end

  // prescaler counts down from all ones; tap bit selects ratio
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prescaler_live_count <= `DTP_PRESCALE_RESET; // [R16]
    end else if (src_tick && ctrl_one[`DTP_BIT_RUN]) begin
      prescaler_live_count <= prescaler_live_count - 8'h01;
    end
  end

  // tick when the selected tap wraps: ratio 2 << code
  always_comb begin
    if (ctrl_two[`DTP_BIT_BYPASS_N]) begin
      count_tick = src_tick; // [R8]
    end else begin
      count_tick = src_tick && (prescaler_live_count[ctrl_two[2:0]] == 1'b0) &&
        ((prescaler_live_count & ((8'h01 << ctrl_two[2:0]) - 8'h01)) == 8'h00); // [R7]
    end
  end

  assign counter_write = wr_hit(reg_wr, reg_addr, `DTP_ADDR_COUNTER);
  assign clear_write = wr_hit(reg_wr, reg_addr, `DTP_ADDR_IRQ_STATUS) && reg_wdata[`DTP_UNDERFLOW_BIT];
  assign underflow = count_tick && ctrl_one[`DTP_BIT_RUN] && !stopped && !counter_write && (count == `DTP_COUNT_ZERO);

  // the down counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= `DTP_COUNT_ZERO;
      stopped <= 1'b0;
    end else if (wr_hit(reg_wr, reg_addr, `DTP_ADDR_COUNTER)) begin
      count <= join10(shared_high_bits[5:4], reg_wdata); // [R2]
      stopped <= 1'b0;
    end else if (count_tick && ctrl_one[`DTP_BIT_RUN] && !stopped) begin // [R3]
      if (count != `DTP_COUNT_ZERO) begin
        count <= count - 10'h001; // [R1]
      end else if (ctrl_one[`DTP_BIT_ONESHOT]) begin
        stopped <= 1'b1; // [R6]
      end else if (ctrl_one[`DTP_BIT_RELOAD]) begin
        count <= join10(shared_high_bits[5:4], reload_low); // [R5]
      end else begin
        count <= `DTP_COUNT_TOP; // [R4]
      end
    end
  end

  // pwm compare and output stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwm_one <= 1'b0;
      pwm_two <= 1'b0;
    end else begin
      pwm_one <= count < join10(shared_high_bits[1:0], first_channel_duty); // [R13] [R18]
      pwm_two <= count < join10(shared_high_bits[3:2], second_channel_duty); // [R17] [R18]
    end
  end
  assign first_channel_out = pwm_one ^ ctrl_one[`DTP_BIT_POL]; // [R11]
  assign first_channel_out_en = ctrl_one[`DTP_BIT_PIN_EN]; // [R12]
  assign second_channel_out = pwm_two ^ ctrl_ch2[0]; // [R14]
  assign second_channel_out_en = ctrl_ch2[1]; // [R15]

  // interrupt status, set wins over clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_status <= 1'b0;
    end else if (underflow) begin
      irq_status <= 1'b1; // [R19]
    end else if (clear_write) begin
      irq_status <= 1'b0;
    end
  end
  assign irq = |(irq_status & irq_mask);

  // read mux
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      `DTP_ADDR_COUNTER: next_rdata = count[7:0]; // [R1]
      `DTP_ADDR_CTRL_ONE: next_rdata = {ctrl_one[7:6], 3'h0, ctrl_one[2:0]};
      `DTP_ADDR_CTRL_TWO: next_rdata = {2'h0, ctrl_two};
      `DTP_ADDR_PRESCALE: next_rdata = prescaler_live_count; // [R16]
      `DTP_ADDR_CTRL_CH2: next_rdata = {ctrl_ch2, 6'h00};
      `DTP_ADDR_HIGH_BITS: next_rdata = {2'h0, shared_high_bits};
      `DTP_ADDR_IRQ_STATUS: next_rdata = {7'h00, irq_status};
      `DTP_ADDR_IRQ_MASK: next_rdata = {7'h00, irq_mask};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // checks
  sequence s_load_write;
    counter_write;
  endsequence

  sequence s_count_step;
    count_tick && ctrl_one[`DTP_BIT_RUN] && !stopped && !counter_write && count != `DTP_COUNT_ZERO;
  endsequence

  sequence s_pwm_one_steady;
    ##1 $stable(count) && $stable(first_channel_duty) && $stable(shared_high_bits);
  endsequence

  chk_counter_load: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
    s_load_write |=> count == join10($past(shared_high_bits[5:4]), $past(reg_wdata)))
    else $error("counter load wrong");
  chk_halt_holds: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
    !ctrl_one[`DTP_BIT_RUN] && !counter_write |=> $stable(count))
    else $error("counter moved while halted");
  chk_wrap_top: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
    underflow && !ctrl_one[`DTP_BIT_ONESHOT] && !ctrl_one[`DTP_BIT_RELOAD] && !reg_wr
    |=> count == `DTP_COUNT_TOP)
    else $error("no wrap to top");
  chk_wrap_reload: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
    underflow && !ctrl_one[`DTP_BIT_ONESHOT] && ctrl_one[`DTP_BIT_RELOAD] && !reg_wr
    |=> count == join10($past(shared_high_bits[5:4]), $past(reload_low)))
    else $error("no reload on underflow");
  chk_oneshot_stop: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
    underflow && ctrl_one[`DTP_BIT_ONESHOT] && !reg_wr |=> stopped && count == `DTP_COUNT_ZERO)
    else $error("one-shot did not stop");
  chk_irq_set: assert property (@(posedge clk_sys) disable iff (rst) // [R19]
    underflow |=> irq_status[0] ##0 (irq == irq_mask[0]))
    else $error("underflow flag missing");
  chk_pwm_one: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
    ctrl_one[`DTP_BIT_POL] && !pwm_one |-> first_channel_out)
    else $error("first polarity wrong");
  chk_pwm_two: assert property (@(posedge clk_sys) disable iff (rst) // [R18]
    ##1 $stable(count) && $stable(second_channel_duty) && $stable(shared_high_bits)
    |-> pwm_two == (count < join10(shared_high_bits[3:2], second_channel_duty)))
    else $error("second compare wrong");
  chk_bypass_tick: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
    ctrl_two[`DTP_BIT_BYPASS_N] |-> count_tick == src_tick)
    else $error("bypass not honoured");

  chk_down_step: assert property (@(posedge clk_sys) disable iff (rst) // [R1]
    s_count_step |=> count == $past(count) - 10'h001)
    else $error("counter did not step down");
  chk_read_count: assert property (@(posedge clk_sys) disable iff (rst) // [R1]
    reg_rd && reg_addr == `DTP_ADDR_COUNTER |=> reg_rdata == $past(count[7:0]))
    else $error("counter read wrong");
  chk_run_gate: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
    !ctrl_one[`DTP_BIT_RUN] |-> !underflow)
    else $error("underflow while halted");
  chk_oneshot_hold: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
    stopped && !counter_write |=> stopped && $stable(count))
    else $error("one-shot left stop");

  chk_ratio_gap: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
    !ctrl_two[`DTP_BIT_BYPASS_N] && count_tick |=> ctrl_two[`DTP_BIT_BYPASS_N] || !count_tick)
    else $error("divided ticks too close");
  chk_prescale_step: assert property (@(posedge clk_sys) disable iff (rst) // [R16]
    src_tick && ctrl_one[`DTP_BIT_RUN] |=> prescaler_live_count == $past(prescaler_live_count) - 8'h01)
    else $error("prescaler did not step");
  chk_prescale_idle: assert property (@(posedge clk_sys) disable iff (rst) // [R16]
    !(src_tick && ctrl_one[`DTP_BIT_RUN]) |=> $stable(prescaler_live_count))
    else $error("prescaler moved while idle");
  chk_read_prescale: assert property (@(posedge clk_sys) disable iff (rst) // [R16]
    reg_rd && reg_addr == `DTP_ADDR_PRESCALE |=> reg_rdata == $past(prescaler_live_count))
    else $error("prescaler read wrong");

  chk_edge_fall: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
    src == dtp_pkg::DTP_SRC_EXT && ctrl_two[`DTP_BIT_EDGE] |-> src_tick == pin_fall)
    else $error("falling edge not used");
  chk_edge_rise: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
    src == dtp_pkg::DTP_SRC_EXT && !ctrl_two[`DTP_BIT_EDGE] |-> src_tick == pin_rise)
    else $error("rising edge not used");
  chk_no_false_edge: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
    !pin_seen |-> !pin_rise && !pin_fall)
    else $error("edge before pin settled");
  chk_instr_gap: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
    !ctrl_two[`DTP_BIT_SOURCE] && src_tick |=> ctrl_two[`DTP_BIT_SOURCE] || !src_tick)
    else $error("instruction ticks too close");
  chk_pin_source: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
    ctrl_two[`DTP_BIT_SOURCE] && !pin_rise && !pin_fall |-> !src_tick)
    else $error("tick without pin edge");

  chk_irq_hold: assert property (@(posedge clk_sys) disable iff (rst) // [R19]
    irq_status[0] && !clear_write |=> irq_status[0])
    else $error("flag lost without clear");
  chk_irq_clear: assert property (@(posedge clk_sys) disable iff (rst) // [R19]
    clear_write && !underflow |=> !irq_status[0])
    else $error("flag not cleared");

  chk_pwm_one_cmp: assert property (@(posedge clk_sys) disable iff (rst) // [R13]
    s_pwm_one_steady |-> pwm_one == (count < join10(shared_high_bits[1:0], first_channel_duty)))
    else $error("first compare wrong");
  chk_pwm_two_pol: assert property (@(posedge clk_sys) disable iff (rst) // [R14]
    ctrl_ch2[0] && !pwm_two |-> second_channel_out)
    else $error("second polarity wrong");
  chk_pin_en_one: assert property (@(posedge clk_sys) disable iff (rst) // [R12]
    first_channel_out_en == ctrl_one[`DTP_BIT_PIN_EN])
    else $error("first pin enable wrong");
  chk_pin_en_two: assert property (@(posedge clk_sys) disable iff (rst) // [R15]
    second_channel_out_en == ctrl_ch2[1])
    else $error("second pin enable wrong");
endmodule
`default_nettype wire

/* testbench/down_timer_with_two_pwm_tb_top.sv */
/*
  Self-checking bench of the down timer with two PWM channels.
  Assumes dtp_timer with its register port and one 20 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module down_timer_with_two_pwm_tb_top;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, pin = 1;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d, hb = 0, c1, p4;
  logic o1, e1, o2, e2, irq;
  int fail_count = 0, n_checks = 0, cyc = 0, cnt, rl, os, rv, stp, d1, d2, v;
  initial forever #25 clk_sys = ~clk_sys;
  dtp_timer uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_count_pin(pin), .first_channel_out(o1),
    .first_channel_out_en(e1), .second_channel_out(o2), .second_channel_out_en(e2), .irq(irq));
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pin <= 0;
      repeat (4) @(posedge clk_sys);
      pin <= 1;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  // model of the counter: one call applies n count ticks
  task automatic mtick(input int n);
    repeat (n) if (stp == 0) begin
      if (cnt == 0) begin
        if (os != 0) stp = 1;
        else cnt = (rv != 0) ? rl : 'h3FF;
      end else cnt--;
    end
  endtask
  task automatic load(input int w);
    hb[5:4] = w[9:8];
    wr(8'h15, hb);
    wr(8'h10, w[7:0]);
    cnt = w;
    rl = w;
    stp = 0;
  endtask
  task automatic ext(input logic [7:0] c2, input logic [7:0] c, input int w, input int n, input int t);
    wr(8'h12, c2);
    load(w);
    os = c[2];
    rv = c[1];
    wr(8'h11, c | 8'h01);
    pulse(n);
    repeat (6) @(posedge clk_sys);
    wr(8'h11, c);
    pulse(2);
    rd(8'h10);
    mtick(t);
    `CHK("count", cnt[7:0], d)
  endtask
  task automatic end_of_test;
    $display("fail_count %0d n_checks %0d", fail_count, n_checks);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      end_of_test;
    end
  end
  initial begin
    void'($urandom(32'h246b8d59));
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    wr(8'h14, 8'h00);
    rd(8'h14);
    `CHK("prescale", 8'hFF, d)
    rd(8'h12);
    `CHK("ctrl_two", 8'h3F, d)
    rd(8'h1F);
    `CHK("unmapped", 8'h00, d)
    `CHK("irq", 1'b0, irq)
    for (int i = 0; i < 4; i++) begin
      v = 1 + $urandom % 20;
      ext(i[0] ? 8'h38 : 8'h28, 8'h00, 'h300 | ($urandom % 256), v, v);
    end
    ext(8'h38, 8'h00, 3, 6, 6);
    rd(8'h19);
    `CHK("status", 1'b1, d[0])
    `CHK("irq masked", 1'b0, irq)
    wr(8'h1A, 8'h01);
    #1;
    `CHK("irq", 1'b1, irq)
    wr(8'h19, 8'h01);
    rd(8'h19);
    `CHK("status clr", 1'b0, d[0])
    `CHK("irq clr", 1'b0, irq)
    ext(8'h38, 8'h02, 3, 6, 6);
    ext(8'h38, 8'h04, 3, 6, 6);
    for (int c = 0; c < 8; c++) begin
      wr(8'h12, 8'h38 | c);
      ext(8'h30 | c, 8'h00, 'h3FF, (2 << c) * (c < 3 ? 3 : 1), c < 3 ? 3 : 1);
    end
    wr(8'h12, 8'h08);
    load('h3FF);
    wr(8'h11, 8'h01);
    repeat (40) @(posedge clk_sys);
    wr(8'h11, 8'h00);
    rd(8'h10);
    `CHK("instr ticks", 1'b1, (8'hFF - d) >= 9 && (8'hFF - d) <= 12)
    for (int i = 0; i < 8; i++) begin
      v = $urandom % 1024;
      d1 = (i == 0) ? v : $urandom % 1024;
      d2 = $urandom % 1024;
      c1 = $urandom & 8'hC0;
      p4 = $urandom & 8'hC0;
      hb = {4'h0, d2[9:8], d1[9:8]};
      wr(8'h13, d1[7:0]);
      wr(8'h18, d2[7:0]);
      wr(8'h16, p4);
      wr(8'h11, c1);
      load(v);
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("out1", (v < d1) ^ c1[6], o1)
      `CHK("en1", c1[7], e1)
      `CHK("out2", (v < d2) ^ p4[6], o2)
      `CHK("en2", p4[7], e2)
    end
    end_of_test;
  end
endmodule
`default_nettype wire
